// *** logic/weekly_exercise_timer.sv ***
/*
  weekly exercise timer: three-button front panel, 7-day clock, per-day
  start/stop programs, ring and symbol display, exercise output, and an
  axi4-lite register slave.
  assumes: buttons active high and synchronous to clk; one write and one
  read at most outstanding on the bus.
*/
// The register offsets and the AXI4-Lite register port were decided locally.
// What this block does
// - all three buttons clear time, show dashes
// - first arrow: day setting, flashing clock, 0:00
// - plus advances day, monday is 1
// - next arrow: hour setting, 24-hour plus steps
// - next arrow: minutes, plus +1, held +5
// - eight more arrows return to running mode
// - four arrows from running enter program mode
// - program indicator flashes when nothing stored
// - arrow steps selected program day
// - plus with set erases selected day
// - edit starts midnight, plus +1, held +15
// - first set stores start, second stores stop
// - ring segments show each stored span
// - arrow copies program into empty next day
// - ellipse shows on during exercise, else off
// - set in running mode starts test run
// - second set ends the test run
// - set during program period overrides, again restores
// - held set enters permanent mode, output on
// - set tap toggles permanent on and off
// - held set leaves permanent mode again
// - 7-day clock, four programs per day, min one minute
// - exercise output low requests a run
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.svh"
module weekly_exercise_timer
  import timer_pkg::*;
#(
  parameter int unsigned     DEB_CYCLES    = `DEB_MS * `CYC_PER_MS,
  parameter int unsigned     HOLD_CYCLES   = `HOLD_MS * `CYC_PER_MS,
  parameter int unsigned     REP_CYCLES    = `REP_MS * `CYC_PER_MS,
  parameter int unsigned     BLINK_CYCLES  = `BLINK_MS * `CYC_PER_MS,
  parameter longint unsigned MINUTE_CYCLES = 64'(`MINUTE_S) * 1000 * `CYC_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        btn_arrow,
  input  wire logic        btn_plus,
  input  wire logic        btn_set,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             exercise_n,
  output logic [23:0]      ring_seg,
  output logic [2:0]       disp_day,
  output logic [4:0]       disp_hour,
  output logic [5:0]       disp_min,
  output logic             time_dashes,
  output logic             sym_clock,
  output logic             sym_hand,
  output logic             sym_small_hand,
  output logic             prog_ind,
  output logic             ellipse_on
);
  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic mod_t wrap_add(input mod_t v, input mod_t inc, input mod_t lim);
    mod_t s;
    s = v + inc;
    return (s >= lim) ? s - lim : s;
  endfunction

  // minute-of-day step with carry into the hour; the step never exceeds 59
  function automatic mod_t step_hm(input logic [4:0] h, input logic [5:0] m, input mod_t inc);
    mod_t s;
    mod_t hh;
    s  = {5'h0, m} + inc;
    hh = {6'h0, h};
    if (s >= `MIN_LIM) begin
      s  = s - `MIN_LIM;
      hh = wrap_add(hh, `STEP_ONE, `HOUR_LIM);
    end
    return {hh[4:0], s[5:0]};
  endfunction

  function automatic mod_t mod_of(input logic [4:0] h, input logic [5:0] m);
    return mod_t'({6'h0, h} * `MIN_LIM + {5'h0, m});
  endfunction

  // a stop earlier than its start runs across midnight
  function automatic logic in_span(input mod_t t, input mod_t st, input mod_t sp);
    return (st <= sp) ? (t >= st && t < sp) : (t >= st || t < sp);
  endfunction

  function automatic logic [23:0] ring_of(input logic [43:0] st, input logic [43:0] sp,
                                          input logic [3:0] v);
    logic [23:0] r;
    mod_t        h0;
    mod_t        s;
    mod_t        e;
    r = '0;
    for (int h = 0; h < 24; h++) begin
      h0 = mod_t'(h) * `MIN_LIM;
      for (int k = 0; k < `SLOTS; k++) begin
        s = st[k*`SLOT_W +: `SLOT_W];
        e = sp[k*`SLOT_W +: `SLOT_W];
        if (v[k] && (in_span(h0, s, e) || (s >= h0 && s < h0 + `MIN_LIM))) begin
          r[h] = 1'b1;
        end
      end
    end
    return r;
  endfunction

  function automatic logic hit_of(input mod_t t, input logic [43:0] st, input logic [43:0] sp,
                                  input logic [3:0] v);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < `SLOTS; k++) begin
      if (v[k] && in_span(t, st[k*`SLOT_W +: `SLOT_W], sp[k*`SLOT_W +: `SLOT_W])) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // buttons
  logic a_lvl, a_press, a_tap, a_hold, a_rep;
  logic p_lvl, p_press, p_tap, p_hold, p_rep;
  logic s_lvl, s_press, s_tap, s_hold, s_rep;

  button_filter #(.DEB_CYCLES(DEB_CYCLES), .HOLD_CYCLES(HOLD_CYCLES),
                  .REP_CYCLES(REP_CYCLES)) u_arrow (
    .clk(clk), .reset_n(reset_n), .raw(btn_arrow), .level(a_lvl), .press(a_press),
    .tap(a_tap), .hold(a_hold), .rep(a_rep));
  button_filter #(.DEB_CYCLES(DEB_CYCLES), .HOLD_CYCLES(HOLD_CYCLES),
                  .REP_CYCLES(REP_CYCLES)) u_plus (
    .clk(clk), .reset_n(reset_n), .raw(btn_plus), .level(p_lvl), .press(p_press),
    .tap(p_tap), .hold(p_hold), .rep(p_rep));
  button_filter #(.DEB_CYCLES(DEB_CYCLES), .HOLD_CYCLES(HOLD_CYCLES),
                  .REP_CYCLES(REP_CYCLES)) u_set (
    .clk(clk), .reset_n(reset_n), .raw(btn_set), .level(s_lvl), .press(s_press),
    .tap(s_tap), .hold(s_hold), .rep(s_rep));

  ////////////////////////////////////////////////////////////////////////
  // state
  mode_t       mode_r;
  logic [3:0]  acnt_r;
  logic        all3_r;
  logic        combo_seen_r;
  logic [2:0]  day_r;
  logic [4:0]  hour_r;
  logic [5:0]  min_r;
  logic [32:0] tick_r;
  logic [31:0] blink_cnt_r;
  logic        blink_r;
  logic [43:0] st_r [0:6];
  logic [43:0] sp_r [0:6];
  logic [3:0]  vld_r [0:6];
  logic [2:0]  sel_day_r;
  logic [4:0]  eh_r;
  logic [5:0]  em_r;
  mod_t        on_val_r;
  logic [1:0]  slot_r;
  logic        test_r;
  logic        ovr_r;
  logic        perm_r;
  logic        perm_on_r;
  logic [31:0] ctrl_r;

  // decode
  wire       all3      = a_lvl && p_lvl && s_lvl;
  wire       clr_evt   = all3 && !all3_r;
  wire       a_step    = a_press && !all3;
  wire       combo_ps  = (s_press && p_lvl) || (p_press && s_lvl);
  wire       in_prog   = (mode_r == M_PROG) || (mode_r == M_EDIT_ON) || (mode_r == M_EDIT_OFF);
  wire       in_edit   = (mode_r == M_EDIT_ON) || (mode_r == M_EDIT_OFF);
  wire       setting   = (mode_r == M_SET_DAY) || (mode_r == M_SET_HOUR) ||
                         (mode_r == M_SET_MIN);
  wire       time_ok   = (mode_r == M_RUN) || in_prog;
  wire [2:0] cur_i     = day_r - `DAY_FIRST;
  wire [2:0] sel_i     = sel_day_r - `DAY_FIRST;
  wire [2:0] nxt_i     = sel_day_r;
  wire       last_day  = sel_day_r == `DAY_LAST;
  wire       enter_pg  = (mode_r == M_RUN) && a_step && (acnt_r == `ARROWS_TO_PROG - 4'h1);
  wire mod_t now_mod   = mod_of(hour_r, min_r);
  wire mod_t edit_mod  = mod_of(eh_r, em_r);
  wire       prog_hit  = hit_of(now_mod, st_r[cur_i], sp_r[cur_i], vld_r[cur_i]);
  wire [2:0] show_i    = in_prog ? sel_i : cur_i;
  wire [23:0] ring_prg = ring_of(st_r[show_i], sp_r[show_i], vld_r[show_i]);
  wire [1:0] free_slot = !vld_r[sel_i][0] ? 2'h0 : !vld_r[sel_i][1] ? 2'h1 :
                         !vld_r[sel_i][2] ? 2'h2 : 2'h3;
  wire       tick_end  = tick_r == 33'(MINUTE_CYCLES - 1);
  wire       active    = perm_r ? perm_on_r :
                         (test_r || (prog_hit && !ovr_r) || ctrl_r[`CTRL_SW_TEST]);
  logic      any_vld;
  always_comb begin
    any_vld = 1'b0;
    for (int d = 0; d < 7; d++) begin
      any_vld = any_vld || (vld_r[d] != 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operating mode and arrow counting
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_r <= M_CLEARED;
      acnt_r <= '0;
    end else if (clr_evt) begin
      mode_r <= M_CLEARED;
      acnt_r <= '0;
    end else if (a_step) begin
      unique case (mode_r)
        M_CLEARED:  mode_r <= M_SET_DAY;
        M_SET_DAY:  mode_r <= M_SET_HOUR;
        M_SET_HOUR: mode_r <= M_SET_MIN;
        M_SET_MIN:  begin
          acnt_r <= (acnt_r == `ARROWS_TO_RUN - 4'h1) ? 4'h0 : acnt_r + 4'h1;
          if (acnt_r == `ARROWS_TO_RUN - 4'h1) mode_r <= M_RUN;
        end
        M_RUN:      begin
          acnt_r <= enter_pg ? 4'h0 : acnt_r + 4'h1;
          if (enter_pg) mode_r <= M_PROG;
        end
        M_PROG:     if (last_day) mode_r <= M_RUN;
        M_EDIT_ON,
        M_EDIT_OFF: mode_r <= M_PROG;
      endcase
    end else if (mode_r == M_PROG && p_tap && !combo_seen_r) begin
      mode_r <= M_EDIT_ON;
    end else if (mode_r == M_EDIT_ON && s_press) begin
      mode_r <= M_EDIT_OFF;
    end else if (mode_r == M_EDIT_OFF && s_press) begin
      mode_r <= M_PROG;
    end
  end

  // a plus released after plus+set must not open an edit
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      all3_r       <= 1'b0;
      combo_seen_r <= 1'b0;
    end else begin
      all3_r       <= all3;
      combo_seen_r <= combo_ps ? 1'b1 : (p_press ? 1'b0 : combo_seen_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time of day
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      day_r  <= `DAY_FIRST;
      hour_r <= '0;
      min_r  <= '0;
      tick_r <= '0;
    end else if (clr_evt || (mode_r == M_CLEARED && a_step)) begin
      day_r  <= `DAY_FIRST;
      hour_r <= '0;
      min_r  <= '0;
      tick_r <= '0;
    end else if (setting) begin
      tick_r <= '0;
      if (mode_r == M_SET_DAY && p_press) begin
        day_r <= (day_r == `DAY_LAST) ? `DAY_FIRST : day_r + 3'h1;
      end
      if (mode_r == M_SET_HOUR && (p_press || p_rep)) begin
        hour_r <= (hour_r == `HOUR_LAST) ? 5'h0 : hour_r + 5'h1;
      end
      if (mode_r == M_SET_MIN && (p_press || p_rep)) begin
        min_r <= 6'(wrap_add({5'h0, min_r}, p_rep ? `STEP_CLK : `STEP_ONE, `MIN_LIM));
      end
    end else if (time_ok) begin
      tick_r <= tick_end ? 33'h0 : tick_r + 33'h1;
      if (tick_end) begin
        {hour_r, min_r} <= step_hm(hour_r, min_r, `STEP_ONE);
        if (now_mod == `DAY_MINS - `STEP_ONE) begin
          day_r <= (day_r == `DAY_LAST) ? `DAY_FIRST : day_r + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // program store, day selection and editing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int d = 0; d < 7; d++) begin
        st_r[d]  <= '0;
        sp_r[d]  <= '0;
        vld_r[d] <= '0;
      end
      sel_day_r <= `DAY_FIRST;
      eh_r      <= '0;
      em_r      <= '0;
      on_val_r  <= '0;
      slot_r    <= '0;
    end else begin
      if (enter_pg) sel_day_r <= `DAY_FIRST;
      if (mode_r == M_PROG && a_step && !last_day) begin
        sel_day_r <= sel_day_r + 3'h1;
        if (vld_r[sel_i] != 4'h0 && vld_r[nxt_i] == 4'h0) begin
          st_r[nxt_i]  <= st_r[sel_i];
          sp_r[nxt_i]  <= sp_r[sel_i];
          vld_r[nxt_i] <= vld_r[sel_i];
        end
      end
      if (mode_r == M_PROG && combo_ps) vld_r[sel_i] <= 4'h0;
      if (mode_r == M_PROG && p_tap && !combo_seen_r) begin
        eh_r   <= '0;
        em_r   <= '0;
        slot_r <= free_slot;
      end
      if (in_edit && (p_press || p_rep)) begin
        {eh_r, em_r} <= step_hm(eh_r, em_r, p_rep ? `STEP_PROG : `STEP_ONE);
      end
      if (mode_r == M_EDIT_ON && s_press) on_val_r <= edit_mod;
      // an empty span is dropped: every program lasts a minute or more
      if (mode_r == M_EDIT_OFF && s_press && edit_mod != on_val_r) begin
        st_r[sel_i][slot_r*`SLOT_W +: `SLOT_W] <= on_val_r;
        sp_r[sel_i][slot_r*`SLOT_W +: `SLOT_W] <= edit_mod;
        vld_r[sel_i][slot_r]                  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // test run, override and permanent mode (running mode only)
  always_ff @(posedge clk) begin
    if (!reset_n || mode_r != M_RUN) begin
      test_r    <= 1'b0;
      ovr_r     <= 1'b0;
      perm_r    <= 1'b0;
      perm_on_r <= 1'b0;
    end else if (s_hold) begin
      perm_r    <= !perm_r;
      perm_on_r <= !perm_r;
      test_r    <= 1'b0;
      ovr_r     <= 1'b0;
    end else if (s_tap) begin
      if (perm_r) perm_on_r <= !perm_on_r;
      else if (test_r) test_r <= 1'b0;
      else if (prog_hit) ovr_r <= !ovr_r;
      else test_r <= 1'b1;
    end else if (!prog_hit) begin
      ovr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flash timebase
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      blink_cnt_r <= '0;
      blink_r     <= 1'b0;
    end else if (blink_cnt_r == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_r <= '0;
      blink_r     <= !blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // display and exercise outputs, all registered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      exercise_n     <= 1'b1;
      ring_seg       <= '0;
      disp_day       <= `DAY_FIRST;
      disp_hour      <= '0;
      disp_min       <= '0;
      time_dashes    <= 1'b1;
      sym_clock      <= 1'b1;
      sym_hand       <= 1'b0;
      sym_small_hand <= 1'b0;
      prog_ind       <= 1'b0;
      ellipse_on     <= 1'b0;
    end else begin
      exercise_n     <= !active;
      ellipse_on     <= active;
      ring_seg       <= perm_r ? {24{perm_on_r}} : ring_prg;
      disp_day       <= in_prog ? sel_day_r : day_r;
      disp_hour      <= in_edit ? eh_r : hour_r;
      disp_min       <= in_edit ? em_r : min_r;
      time_dashes    <= mode_r == M_CLEARED;
      sym_clock      <= !perm_r && !test_r && !ovr_r && (!setting || blink_r);
      sym_hand       <= test_r || (perm_r && blink_r);
      sym_small_hand <= ovr_r;
      prog_ind       <= in_prog && (any_vld || blink_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  wire         wr_go  = !awready && !wready && !bvalid;
  wire         wr_ctl = aw_addr_r == `OFS_CTRL;
  wire         wr_ok  = wr_ctl || aw_addr_r == `OFS_STATUS || aw_addr_r == `OFS_PROG;
  wire [31:0]  status = {10'h0, perm_on_r, perm_r, ovr_r, test_r, active, mode_r,
                         day_r, hour_r, min_r};
  wire [31:0]  progw  = {3'h0, sel_day_r, any_vld, 21'h0, vld_r[cur_i]};
  wire         rd_ok  = araddr == `OFS_STATUS || araddr == `OFS_CTRL || araddr == `OFS_PROG;
  wire [31:0]  rd_mux = (araddr == `OFS_STATUS) ? status :
                        (araddr == `OFS_CTRL) ? ctrl_r :
                        (araddr == `OFS_PROG) ? progw : 32'h0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      ctrl_r    <= `CTRL_RST;
    end else begin
      if (awvalid && awready) begin
        aw_addr_r <= awaddr;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        wready   <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_ctl && w_strb_r[0]) ctrl_r[`CTRL_SW_TEST] <= w_data_r[`CTRL_SW_TEST];
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_mux;
      rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** logic/timer_map.svh ***
/*
  named offsets, field positions, reset values and timing figures of the
  weekly exercise timer.
  assumes: included by bare name; definitions only.
*/
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
// clock rate and timing figures, each in its own unit
`define CLK_MHZ        100
`define CYC_PER_MS     (`CLK_MHZ * 1000)
`define DEB_MS         20
`define HOLD_MS        2000
`define REP_MS         250
`define BLINK_MS       500
`define MINUTE_S       60
// calendar
`define DAY_FIRST      3'h1
`define DAY_LAST       3'h7
`define HOUR_LIM       11'h018
`define MIN_LIM        11'h03c
`define DAY_MINS       11'h5a0
`define HOUR_LAST      5'h17
`define SLOTS          4
`define SLOT_W         11
// plus steps in minutes
`define STEP_ONE       11'h001
`define STEP_CLK       11'h005
`define STEP_PROG      11'h00f
// arrow counts
`define ARROWS_TO_RUN  4'h8
`define ARROWS_TO_PROG 4'h4
// register map
`define OFS_STATUS     8'h00
`define OFS_CTRL       8'h04
`define OFS_PROG       8'h08
`define CTRL_SW_TEST   0
`define CTRL_RST       32'h0000_0000
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// *** logic/timer_pkg.sv ***
/*
  types shared by the weekly exercise timer.
  assumes: nothing.
*/
package timer_pkg;
  typedef enum logic [2:0] {
    M_CLEARED, M_SET_DAY, M_SET_HOUR, M_SET_MIN,
    M_RUN, M_PROG, M_EDIT_ON, M_EDIT_OFF
  } mode_t;
  typedef logic [10:0] mod_t;
endpackage

// *** logic/button_filter.sv ***
/*
  debounce and press classification for one front-panel button.
  assumes: raw input synchronous to clk, active high while pressed.
*/
`timescale 1ns/1ps
`default_nettype none
module button_filter #(
  parameter int unsigned DEB_CYCLES  = 2,
  parameter int unsigned HOLD_CYCLES = 8,
  parameter int unsigned REP_CYCLES  = 4
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic raw,
  output logic      level,
  output logic      press,
  output logic      tap,
  output logic      hold,
  output logic      rep
);
  logic [31:0] deb_cnt_r;
  logic [31:0] hold_cnt_r;
  logic [31:0] rep_cnt_r;
  logic        long_r;

  ////////////////////////////////////////////////////////////////////////
  // raw must sit still for the whole window before the level follows
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      deb_cnt_r <= '0;
      level     <= 1'b0;
      press     <= 1'b0;
      tap       <= 1'b0;
    end else begin
      press <= 1'b0;
      tap   <= 1'b0;
      if (raw == level) begin
        deb_cnt_r <= '0;
      end else if (deb_cnt_r == 32'(DEB_CYCLES - 1)) begin
        deb_cnt_r <= '0;
        level     <= raw;
        press     <= raw;
        tap       <= !raw && !long_r;
      end else begin
        deb_cnt_r <= deb_cnt_r + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hold threshold, then auto-repeat pulses while still held
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hold_cnt_r <= '0;
      rep_cnt_r  <= '0;
      long_r     <= 1'b0;
      hold       <= 1'b0;
      rep        <= 1'b0;
    end else begin
      hold <= 1'b0;
      rep  <= 1'b0;
      if (!level) begin
        hold_cnt_r <= '0;
        rep_cnt_r  <= '0;
        long_r     <= 1'b0;
      end else if (!long_r) begin
        if (hold_cnt_r == 32'(HOLD_CYCLES - 1)) begin
          long_r <= 1'b1;
          hold   <= 1'b1;
        end else begin
          hold_cnt_r <= hold_cnt_r + 32'h1;
        end
      end else if (rep_cnt_r == 32'(REP_CYCLES - 1)) begin
        rep_cnt_r <= '0;
        rep       <= 1'b1;
      end else begin
        rep_cnt_r <= rep_cnt_r + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/timer_asserts.sv ***
/* port checker for the exercise timer.
   assumes: bound to weekly_exercise_timer, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module timer_asserts (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        btn_arrow,
  input wire logic        btn_plus,
  input wire logic        btn_set,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        exercise_n,
  input wire logic [2:0]  disp_day,
  input wire logic [4:0]  disp_hour,
  input wire logic [5:0]  disp_min,
  input wire logic        time_dashes,
  input wire logic        sym_clock,
  input wire logic        sym_hand,
  input wire logic        ellipse_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // all three held long enough to clear the debouncers
  sequence all_held;
    (btn_arrow && btn_plus && btn_set) [*8];
  endsequence
  wr_resp_a: assert property (wr_taken |-> ##2 bvalid) else $error("write answer late");
  b_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data moved");
  wr_block_a: assert property (bvalid |-> !awready && !wready) else $error("write reopened");
  rd_block_a: assert property (rvalid |-> !arready) else $error("read reopened");
  ellipse_a: assert property (ellipse_on != exercise_n) else $error("ellipse wrong");
  day_range_a: assert property (disp_day != 3'h0) else $error("day zero");
  time_range_a: assert property (disp_hour <= 5'h17 && disp_min <= 6'h3b)
    else $error("time out of range");
  clear_dash_a: assert property (all_held |-> ##[0:4] time_dashes) else $error("no clear");
  hand_clock_a: assert property (sym_hand |-> !sym_clock) else $error("hand and clock");
endmodule
bind weekly_exercise_timer timer_asserts chk (.*);
`default_nettype wire

// *** sim/button_panel.sv ***
/* operator button model.
   assumes: clk is the timer clock. */
`timescale 1ns/1ps
`default_nettype none
module button_panel (
  input  wire logic clk,
  output logic      btn_arrow,
  output logic      btn_plus,
  output logic      btn_set
);
  initial {btn_arrow, btn_plus, btn_set} = 3'h0;
  // rest after release so the debouncer settles before the next press
  task automatic push(input logic [2:0] m, input int n);
    @(posedge clk);
    {btn_arrow, btn_plus, btn_set} <= m;
    repeat (n) @(posedge clk);
    {btn_arrow, btn_plus, btn_set} <= 3'h0;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
/* self-checking bench for the exercise timer.
   assumes: shortened counts; random tap lengths from a fixed seed. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module testbench;
  logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, exercise_n, time_dashes, sym_clock, sym_hand, sym_small_hand;
  logic prog_ind, ellipse_on, btn_arrow, btn_plus, btn_set;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [23:0] ring_seg;
  logic [2:0]  disp_day;
  logic [4:0]  disp_hour;
  logic [5:0]  disp_min;
  int          mismatches, n_compared, seed, n;
  weekly_exercise_timer #(.DEB_CYCLES(2), .HOLD_CYCLES(20), .REP_CYCLES(8),
    .BLINK_CYCLES(4), .MINUTE_CYCLES(10)) dut (.*);
  button_panel pnl (.*);
  ////////////////////////////////////////////////////////////
  function automatic int rnd(input int k);
    return 1 + ($unsigned($random(seed)) % k);
  endfunction
  task automatic key(input logic [2:0] m);
    pnl.push(m, 2 + rnd(12));
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'h7;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (i == 40) begin mismatches++; results; end
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
    if (i == 40) begin mismatches++; results; end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    seed = 32'h0bbc13ea;
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0000_0000_0000_f;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    key(3'h7);
    `CHK("dashes", 1'b1, time_dashes)
    key(3'h4);
    `CHK("dashes", 1'b0, time_dashes)
    `CHK("midnight", 11'h0, {disp_hour, disp_min})
    n = rnd(9);
    repeat (n) key(3'h2);
    `CHK("day", 3'(n % 7 + 1), disp_day)
    key(3'h4);
    n = rnd(28);
    repeat (n) key(3'h2);
    `CHK("hour", 5'(n % 24), disp_hour)
    key(3'h4);
    n = rnd(6);
    repeat (n) key(3'h2);
    `CHK("minute", 6'(n), disp_min)
    repeat (8) key(3'h4);
    // a blinking symbol would show low within one blink period
    repeat (6) @(negedge clk) `CHK("clock", 1'b1, sym_clock)
    $display("time setting done");
    key(3'h1);
    `CHK("hand", 1'b1, sym_hand)
    `CHK("run", 1'b0, exercise_n)
    key(3'h1);
    `CHK("run", 1'b1, exercise_n)
    $display("test run done");
    wr(8'h04, 32'h1);
    `CHK("resp", 2'h0, r)
    repeat (3) @(posedge clk);
    `CHK("run", 1'b0, exercise_n)
    rd(8'h40);
    `CHK("resp", 2'h2, r)
    `CHK("rdata", 32'h0, d)
    wr(8'h04, 32'h0);
    repeat (3) @(posedge clk);
    `CHK("run", 1'b1, exercise_n)
    $display("bus done");
    repeat (4) key(3'h4);
    n = 0;
    repeat (6) @(negedge clk) n += prog_ind;
    `CHK("pr blink", 1'b1, n > 0 && n < 6)
    key(3'h2);
    key(3'h1);
    repeat (2) key(3'h2);
    `CHK("edit", 11'h2, {disp_hour, disp_min})
    key(3'h1);
    `CHK("band", 24'h1, ring_seg)
    repeat (6) @(negedge clk) `CHK("pr", 1'b1, prog_ind)
    key(3'h4);
    `CHK("sel", 3'h2, disp_day)
    `CHK("copy", 24'h1, ring_seg)
    key(3'h3);
    `CHK("erase", 24'h0, ring_seg)
    repeat (6) key(3'h4);
    $display("program done");
    // set held past the hold threshold, released well before a second one
    pnl.push(3'h1, 30);
    `CHK("perm on", 24'hffffff, ring_seg)
    key(3'h1);
    `CHK("perm off", 1'b1, exercise_n)
    `CHK("perm ring", 24'h0, ring_seg)
    pnl.push(3'h1, 30);
    `CHK("clock", 1'b1, sym_clock)
    key(3'h7);
    `CHK("dashes", 1'b1, time_dashes)
    $display("panel modes done");
    results;
  end
endmodule
`default_nettype wire
